// ### hw/cmbd_pkg.sv
// Purpose: shared types and constants of the move/bit/branch decoder
// Assumes: one system clock, opcodes delivered one byte at a time
// Notes: cycle counts are enabled system clock cycles (ce high)
package cmbd_pkg;
  // ----------------------------------------------------------------
  // instruction lengths and execution times
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [3:0] CYC2 = 4'h2;
  localparam logic [3:0] CYC4 = 4'h4;
  localparam logic [3:0] CYC_MIN = 4'h1;
  localparam logic [3:0] CYC_MAX = 4'h8;
  localparam logic [3:0] OP_HI_BIT_CLEAR = 4'h1;  // high nibble of bit-test-and-clear jump
  localparam logic [3:0] OP_HI_JB = 4'h2;   // high nibble of jump on bit set

  // ----------------------------------------------------------------
  // operation classes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CLS_NONE = 5'h00, CLS_MOVE = 5'h01, CLS_MOV_A_IMM = 5'h02, CLS_MOV_R_IMM = 5'h03,
    CLS_MOV_R_DIR = 5'h04, CLS_MOV_DIR_DIR = 5'h05, CLS_MOV_DIR_IND = 5'h06,
    CLS_MOV_IND_DIR = 5'h07, CLS_MOV_DATA_POINTER = 5'h08, CLS_CODE_READ = 5'h09,
    CLS_XDATA_RD = 5'h0a, CLS_XDATA_WR = 5'h0b, CLS_PUSH = 5'h0c, CLS_POP = 5'h0d,
    CLS_XCH = 5'h0e, CLS_NIBBLE_XCH = 5'h0f, CLS_BIT_LOGIC = 5'h10, CLS_MOV_C_BIT = 5'h11,
    CLS_MOV_BIT_C = 5'h12, CLS_BIT_SIMPLE = 5'h13, CLS_ABS_CALL = 5'h14,
    CLS_ABS_JUMP = 5'h15, CLS_LONG_CALL = 5'h16, CLS_SHORT_JUMP = 5'h17,
    CLS_JUMP_BIT = 5'h18, CLS_INDEXED_JUMP = 5'h19, CLS_COMPARE_JUMP = 5'h1a, CLS_DECREMENT_JUMP = 5'h1b,
    CLS_BRANCH = 5'h1c, CLS_NOP = 5'h1d
  } cmbd_cls_e;

  typedef struct packed {
    cmbd_cls_e cls;
    logic [1:0] len;
    logic [3:0] cyc;
  } cmbd_dec_s;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPER = 2'b01,
    ST_EXEC = 2'b10
  } cmbd_state_e;
endpackage

// ### hw/cmbd_dec_if.sv
// Purpose: carries an opcode to the decoder and its decoded fields back
// Assumes: purely combinational path
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface cmbd_dec_if;
  import cmbd_pkg::*;
  logic [7:0] opcode;
  cmbd_dec_s dec;
  logic known;
  logic [2:0] reg_sel;
  logic ptr_sel;
  logic [2:0] page;
  modport dec_side (input opcode, output dec, known, reg_sel, ptr_sel, page);
  modport core_side (output opcode, input dec, known, reg_sel, ptr_sel, page);
endinterface
`default_nettype wire

// ### hw/cmbd_decode.sv
// Purpose: opcode table: class, length and execution time
// Assumes: opcode is stable while decoded
// Notes: opcodes outside the covered groups decode as CLS_NONE
`timescale 1ns/1ps
`default_nettype none
module cmbd_decode
  import cmbd_pkg::*;
(
  cmbd_dec_if.dec_side dif
);
  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  function automatic cmbd_dec_s lookup(input logic [7:0] op);
    cmbd_dec_s d;
    d = '{CLS_NONE, LEN1, CYC2};
    casez (op)
      8'b1110_1???, 8'he5, 8'b1110_011?: d = '{CLS_MOVE, (op == 8'he5) ? LEN2 : LEN1, CYC2};
      8'h74: d = '{CLS_MOV_A_IMM, LEN2, CYC2};
      8'b0111_1???: d = '{CLS_MOV_R_IMM, LEN2, CYC2};
      8'b1111_1???, 8'b1111_011?: d = '{CLS_MOVE, LEN1, CYC2};
      8'b1010_1???: d = '{CLS_MOV_R_DIR, LEN2, CYC4};
      8'hf5, 8'b0111_011?: d = '{CLS_MOVE, LEN2, CYC2};
      8'b1000_1???: d = '{CLS_MOVE, LEN2, CYC4};
      8'h85: d = '{CLS_MOV_DIR_DIR, LEN3, CYC4};
      8'b1000_011?: d = '{CLS_MOV_DIR_IND, LEN2, CYC4};
      8'h75: d = '{CLS_MOVE, LEN3, CYC4};
      8'b1010_011?: d = '{CLS_MOV_IND_DIR, LEN2, CYC4};
      8'h90: d = '{CLS_MOV_DATA_POINTER, LEN3, CYC4};
      8'h93, 8'h83: d = '{CLS_CODE_READ, LEN1, CYC4};
      8'he0, 8'b1110_001?: d = '{CLS_XDATA_RD, LEN1, CYC4};
      8'hf0, 8'b1111_001?: d = '{CLS_XDATA_WR, LEN1, CYC4};
      8'hc0: d = '{CLS_PUSH, LEN2, CYC4};
      8'hd0: d = '{CLS_POP, LEN2, CYC4};
      8'b1100_1???, 8'b1100_011?: d = '{CLS_XCH, LEN1, CYC2};
      8'hc5: d = '{CLS_XCH, LEN2, CYC2};
      8'b1101_011?: d = '{CLS_NIBBLE_XCH, LEN1, CYC2};
      8'hc3, 8'hd3, 8'hb3: d = '{CLS_BIT_SIMPLE, LEN1, CYC2};
      8'hc2, 8'hd2, 8'hb2: d = '{CLS_BIT_SIMPLE, LEN2, CYC2};
      8'h82, 8'hb0, 8'h72, 8'ha0: d = '{CLS_BIT_LOGIC, LEN2, CYC4};
      8'ha2: d = '{CLS_MOV_C_BIT, LEN2, CYC2};
      8'h92: d = '{CLS_MOV_BIT_C, LEN2, CYC4};
      8'b???1_0001: d = '{CLS_ABS_CALL, LEN2, CYC4};
      8'b???0_0001: d = '{CLS_ABS_JUMP, LEN2, CYC4};
      8'h12: d = '{CLS_LONG_CALL, LEN3, CYC4};
      8'h02: d = '{CLS_BRANCH, LEN3, CYC4};
      8'h22, 8'h32: d = '{CLS_BRANCH, LEN1, CYC4};
      8'h80: d = '{CLS_SHORT_JUMP, LEN2, CYC4};
      8'h40, 8'h50, 8'h60, 8'h70: d = '{CLS_BRANCH, LEN2, CYC4};
      8'h10, 8'h20, 8'h30: d = '{CLS_JUMP_BIT, LEN3, CYC4};
      8'h73: d = '{CLS_INDEXED_JUMP, LEN1, CYC4};
      8'hb5, 8'hb4, 8'b1011_1???, 8'b1011_011?: d = '{CLS_COMPARE_JUMP, LEN3, CYC4};
      8'b1101_1???: d = '{CLS_DECREMENT_JUMP, LEN2, CYC4};
      8'hd5: d = '{CLS_DECREMENT_JUMP, LEN3, CYC4};
      8'h00: d = '{CLS_NOP, LEN1, CYC2};
      default: d = '{CLS_NONE, LEN1, CYC2};
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  assign dif.dec = lookup(dif.opcode);
  assign dif.known = (dif.dec.cls != CLS_NONE);
  assign dif.reg_sel = dif.opcode[2:0];
  assign dif.ptr_sel = dif.opcode[0];
  assign dif.page = dif.opcode[7:5];
endmodule
`default_nettype wire

// ### hw/cmbd_top.sv
// Purpose: fetch sequencing and timing for move, bit and branch instructions
// Assumes: code bytes arrive on a valid/ready handshake synchronous to clk_sys
// Notes: results are published with an instr_done pulse lasting one enabled cycle
//
// Overview of operation
// - each instruction lasts two or four clock cycles and spans one to three bytes
// - eight-code blocks select the working register from opcode bits two to zero
// - absolute jump and call take opcode bits seven to five as destination bits
// - immediate load to accumulator or working register is two bytes, two cycles
// - direct byte to working register is two bytes, four cycles
// - direct to direct copy is three bytes, four cycles
// - pointer memory to direct byte is two bytes, four cycles, bit zero picks pointer
// - direct byte to pointer memory is two bytes, four cycles
// - sixteen-bit immediate load of data pointer is three bytes, four cycles
// - code byte read relative to data pointer or program counter takes four cycles
// - external data moves are one byte, four cycles, eight or sixteen bit address
// - push and pop of a direct byte are two bytes, four cycles
// - exchange of accumulator with register, direct or pointer memory takes two cycles
// - low nibble exchange is one byte, two cycles
// - carry AND or OR with direct bit or its inverse is two bytes, four cycles
// - bit to carry takes two cycles, carry to bit four, both two bytes
// - long call carries a sixteen-bit target, three bytes, four cycles
// - short jump with signed offset is two bytes, four cycles
// - jumps on bit set, clear, or set-and-clear are three bytes, four cycles
// - indexed jump on accumulator plus data pointer is one byte, four cycles
// - compare and jump if unequal forms are three bytes, four cycles
// - decrement and jump if nonzero is two or three bytes, four cycles
`timescale 1ns/1ps
`default_nettype none
module cmbd_top
  import cmbd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // program memory byte stream
  input wire logic code_valid,
  input wire logic [7:0] code_byte,
  output logic code_ready,
  // tested bit value from the bit-addressable space
  input wire logic bit_value,
  // decoded instruction
  output logic instr_done,
  output logic [7:0] instr_opcode,
  output cmbd_cls_e instr_class,
  output logic [1:0] instr_len,
  output logic [3:0] instr_cycles,
  output logic illegal_op,
  output logic [2:0] working_register,
  output logic pointer_register,
  output logic [7:0] operand1,
  output logic [7:0] operand2,
  output logic [10:0] abs_dest,
  output logic [15:0] long_dest,
  output logic bit_branch_taken,
  output logic bit_clear
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmbd_state_e state_q, state_d;
  cmbd_dec_s dec_q, dec_d;
  logic [7:0] op_q, op_d;
  logic [7:0] opr1_q, opr1_d;
  logic [7:0] opr2_q, opr2_d;
  logic [1:0] need_q, need_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] rsel_q, rsel_d;
  logic psel_q, psel_d;
  logic [2:0] page_q, page_d;
  logic illegal_q, illegal_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic taken_q, taken_d;
  logic clr_q, clr_d;

  cmbd_dec_if dif ();

  cmbd_decode u_decode (
    .dif(dif)
  );

  // ----------------------------------------------------------------
  // handshake and branch decisions
  // ----------------------------------------------------------------
  // only the opcode byte is decoded, so the decoder sees the raw input
  assign dif.opcode = code_byte;
  wire take = ce & ready_q & code_valid;
  wire first_byte = (state_q == ST_IDLE);
  wire last_exec = (state_q == ST_EXEC) && (cnt_q == CYC_MIN);
  wire is_bit_jump = (dec_q.cls == CLS_JUMP_BIT);
  wire is_clear_jump = is_bit_jump && (op_q[7:4] == OP_HI_BIT_CLEAR);
  wire want_set = is_clear_jump || (op_q[7:4] == OP_HI_JB);
  // bit-test jumps branch when the sampled bit matches the wanted level
  wire bit_taken = is_bit_jump && (bit_value == want_set);
  wire clear_now = is_clear_jump && bit_value;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    dec_d = dec_q;
    op_d = op_q;
    opr1_d = opr1_q;
    opr2_d = opr2_q;
    need_d = need_q;
    cnt_d = cnt_q;
    rsel_d = rsel_q;
    psel_d = psel_q;
    page_d = page_q;
    illegal_d = illegal_q;
    ready_d = ready_q;
    done_d = 1'b0;
    taken_d = 1'b0;
    clr_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          op_d = code_byte;
          dec_d = dif.dec;
          illegal_d = ~dif.known;
          rsel_d = dif.reg_sel;
          psel_d = dif.ptr_sel;
          page_d = dif.page;
          opr1_d = 8'h00;
          opr2_d = 8'h00;
          cnt_d = dif.dec.cyc;
          need_d = dif.dec.len - LEN1;
          if (dif.dec.len == LEN1) begin
            state_d = ST_EXEC;
            ready_d = 1'b0;
          end else begin
            state_d = ST_OPER;
          end
        end
      end
      ST_OPER: begin
        if (take) begin
          // operand bytes land in order: first, then second
          if (need_q == (dec_q.len - LEN1)) begin
            opr1_d = code_byte;
          end else begin
            opr2_d = code_byte;
          end
          need_d = need_q - 2'h1;
          if (need_q == 2'h1) begin
            state_d = ST_EXEC;
            ready_d = 1'b0;
          end
        end
      end
      ST_EXEC: begin
        // execution time counted only on enabled cycles
        if (ce) begin
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == CYC_MIN) begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
            done_d = 1'b1;
            taken_d = bit_taken;
            clr_d = clear_now;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ce low holds every flop, pulses included, so a frozen done stays visible
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      dec_q <= '{CLS_NONE, LEN1, CYC2};
      op_q <= 8'h00;
      opr1_q <= 8'h00;
      opr2_q <= 8'h00;
      need_q <= 2'h0;
      cnt_q <= 4'h0;
      rsel_q <= 3'h0;
      psel_q <= 1'b0;
      page_q <= 3'h0;
      illegal_q <= 1'b1;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      taken_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      dec_q <= dec_d;
      op_q <= op_d;
      opr1_q <= opr1_d;
      opr2_q <= opr2_d;
      need_q <= need_d;
      cnt_q <= cnt_d;
      rsel_q <= rsel_d;
      psel_q <= psel_d;
      page_q <= page_d;
      illegal_q <= illegal_d;
      ready_q <= ready_d;
      done_q <= done_d;
      taken_q <= taken_d;
      clr_q <= clr_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign code_ready = ready_q;
  assign instr_done = done_q;
  assign instr_opcode = op_q;
  assign instr_class = dec_q.cls;
  assign instr_len = dec_q.len;
  assign instr_cycles = dec_q.cyc;
  assign illegal_op = illegal_q;
  assign working_register = rsel_q;
  assign pointer_register = psel_q;
  assign operand1 = opr1_q;
  assign operand2 = opr2_q;
  assign abs_dest = {page_q, opr1_q};
  assign long_dest = {opr1_q, opr2_q};
  assign bit_branch_taken = taken_q;
  assign bit_clear = clr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helper: enabled cycles spent in execution for the current instruction
  logic [3:0] chk_exec_n;
  logic [1:0] chk_bytes_n;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chk_exec_n <= 4'h0;
      chk_bytes_n <= 2'h0;
    end else if (ce) begin
      chk_exec_n <= (state_q == ST_EXEC) ? chk_exec_n + 4'h1 : 4'h0;
      chk_bytes_n <= take ? (first_byte ? 2'h1 : chk_bytes_n + 2'h1) : chk_bytes_n;
    end
  end

  chk_exec_time: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(done_q) |-> chk_exec_n == dec_q.cyc)
    else $error("execution time differs from decoded cycle count");

  chk_cycle_range: assert property (@(posedge clk_sys) disable iff (rst)
    done_q |-> (dec_q.cyc >= CYC_MIN) && (dec_q.cyc <= CYC_MAX) && (dec_q.len != 2'h0))
    else $error("cycle count or length out of range");

  chk_byte_count: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(done_q) |-> chk_bytes_n == dec_q.len)
    else $error("bytes taken differ from instruction length");

  chk_reg_select: assert property (@(posedge clk_sys) disable iff (rst)
    done_q |-> working_register == op_q[2:0])
    else $error("working register not from low opcode bits");

  chk_abs_page: assert property (@(posedge clk_sys) disable iff (rst)
    done_q && (dec_q.cls inside {CLS_ABS_CALL, CLS_ABS_JUMP}) |-> abs_dest[10:8] == op_q[7:5])
    else $error("absolute destination page wrong");

  chk_mov_rdir_time: assert property (@(posedge clk_sys) disable iff (rst)
    done_q && (op_q[7:3] == 5'h15) |-> dec_q.cyc == CYC4 && dec_q.len == LEN2)
    else $error("direct to register timing wrong");

  chk_xch_time: assert property (@(posedge clk_sys) disable iff (rst)
    done_q && (dec_q.cls == CLS_XCH) |-> dec_q.cyc == CYC2)
    else $error("exchange not two cycles");

  chk_clear_taken: assert property (@(posedge clk_sys) disable iff (rst)
    ce && last_exec && is_clear_jump |=> bit_clear == $past(bit_value) && bit_branch_taken == bit_clear)
    else $error("bit clear does not follow taken branch");

  chk_no_clear_other: assert property (@(posedge clk_sys) disable iff (rst)
    bit_clear |-> done_q && op_q[7:4] == OP_HI_BIT_CLEAR)
    else $error("bit cleared by a non clearing instruction");

  chk_ready_exec: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_EXEC) |-> !code_ready)
    else $error("code bytes accepted during execution");

  // a done that lingers past one enabled cycle would make the core retire the same instruction twice
  chk_done_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    done_q && ce |=> !done_q)
    else $error("done pulse longer than one enabled cycle");

  chk_taken_bit_only: assert property (@(posedge clk_sys) disable iff (rst)
    bit_branch_taken |-> done_q && dec_q.cls == CLS_JUMP_BIT)
    else $error("branch taken flagged for a non bit jump");

  cov_one_byte: cover property (@(posedge clk_sys) disable iff (rst)
    done_q && dec_q.len == LEN1);
  cov_three_byte: cover property (@(posedge clk_sys) disable iff (rst)
    done_q && dec_q.len == LEN3);
  cov_clear_taken: cover property (@(posedge clk_sys) disable iff (rst) bit_clear);
  cov_back_to_back: cover property (@(posedge clk_sys) disable iff (rst)
    done_q && take);
endmodule
`default_nettype wire

// ### sim/cmbd_pmem_model.sv
// Purpose: program memory model feeding the decoder byte stream
// Assumes: bytes are queued by the bench between clock edges
// Notes: slow mode leaves one idle cycle after every byte taken
`timescale 1ns/1ps
`default_nettype none
module cmbd_pmem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // byte stream
  input wire logic code_ready,
  input wire logic slow,
  output logic code_valid,
  output logic [7:0] code_byte
);
  // ----------------------------------------------------------------
  // byte queue
  // ----------------------------------------------------------------
  logic [7:0] q [$];
  logic [7:0] last;
  logic gap;

  // offer holds until taken; idle bus shows the inverse so a stale byte is never read as good
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q.delete();
      code_valid <= 1'b0;
      code_byte <= 8'h00;
      last = 8'h00;
      gap = 1'b0;
    end else if (ce) begin
      gap = 1'b0;
      if (code_valid && code_ready) begin
        last = q.pop_front();
        gap = slow;
      end
      if (q.size() > 0 && !gap) begin
        code_valid <= 1'b1;
        code_byte <= q[0];
      end else begin
        code_valid <= 1'b0;
        code_byte <= ~last;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/test_cmbd_top.sv
// Purpose: self-checking bench of the move, bit and branch decoder
// Assumes: execution time is counted after the last byte is taken
// Notes: run lasts well under two thousand clock cycles
`timescale 1ns/1ps
`default_nettype none
module test_cmbd_top
  import cmbd_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys, rst, ce, code_valid, code_ready, bit_value, instr_done, illegal_op;
  logic pointer_register, bit_branch_taken, bit_clear, slow, stall, exp_tk, exp_cl;
  logic [7:0] code_byte, instr_opcode, operand1, operand2;
  cmbd_cls_e instr_class;
  logic [1:0] instr_len;
  logic [3:0] instr_cycles;
  logic [2:0] working_register;
  logic [10:0] abs_dest;
  logic [15:0] long_dest;
  int fail_count, num_checks, cyc_cnt;

  cmbd_top i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .code_valid(code_valid), .code_byte(code_byte),
    .code_ready(code_ready), .bit_value(bit_value), .instr_done(instr_done), .instr_opcode(instr_opcode),
    .instr_class(instr_class), .instr_len(instr_len), .instr_cycles(instr_cycles), .illegal_op(illegal_op),
    .working_register(working_register), .pointer_register(pointer_register), .operand1(operand1),
    .operand2(operand2), .abs_dest(abs_dest), .long_dest(long_dest), .bit_branch_taken(bit_branch_taken),
    .bit_clear(bit_clear));

  cmbd_pmem_model i_pm (.clk_sys(clk_sys), .rst(rst), .ce(ce), .code_ready(code_ready), .slow(slow),
    .code_valid(code_valid), .code_byte(code_byte));

  // clock and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one instruction; counts ready-low cycles whose next edge runs, which is the execution time
  task automatic run(input logic [7:0] op, input logic [1:0] ln, input logic [3:0] cy, input cmbd_cls_e cl);
    logic [7:0] b1, b2;
    int lo, w;
    b1 = op ^ 8'h5a;
    b2 = ~op;
    lo = 0;
    w = 0;
    @(negedge clk_sys);
    i_pm.q.push_back(op);
    if (ln > 1) i_pm.q.push_back(b1);
    if (ln > 2) i_pm.q.push_back(b2);
    while (instr_done !== 1'b1 && w < 200) begin
      @(posedge clk_sys);
      ce <= !(stall && w % 3 == 2);
      @(negedge clk_sys);
      if (code_ready === 1'b0 && ce === 1'b1) lo++;
      w++;
    end
    chk(instr_done, 1'b1);
    chk(16'(lo), cy);
    chk(instr_len, ln);
    chk(instr_cycles, cy);
    chk(instr_class, cl);
    chk(instr_opcode, op);
    chk(illegal_op, cl == CLS_NONE);
    chk(working_register, op[2:0]);
    chk(pointer_register, op[0]);
    chk(operand1, ln > 1 ? b1 : 8'h00);
    chk(operand2, ln > 2 ? b2 : 8'h00);
    chk(bit_branch_taken, exp_tk);
    chk(bit_clear, exp_cl);
    if (ln == LEN3) chk(long_dest, {b1, b2});
    if (cl == CLS_ABS_CALL || cl == CLS_ABS_JUMP) chk(abs_dest, {op[7:5], b1});
    // a stretched done must clear before the next instruction is judged
    @(posedge clk_sys);
    ce <= 1'b1;
    @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset(input logic mid);
    if (mid) begin
      @(negedge clk_sys);
      i_pm.q.push_back(8'h85);
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(code_ready, 1'b1);
    chk(instr_done, 1'b0);
    chk(illegal_op, 1'b1);
    chk(instr_len, LEN1);
    chk(instr_cycles, CYC2);
    chk(instr_class, CLS_NONE);
    chk(long_dest, 16'h0000);
    if (mid) run(8'h00, LEN1, CYC2, CLS_NOP);
  endtask

  task automatic s_table;
    run(8'h74, LEN2, CYC2, CLS_MOV_A_IMM); run(8'h7a, LEN2, CYC2, CLS_MOV_R_IMM);
    run(8'hac, LEN2, CYC4, CLS_MOV_R_DIR); run(8'h85, LEN3, CYC4, CLS_MOV_DIR_DIR);
    run(8'h86, LEN2, CYC4, CLS_MOV_DIR_IND); run(8'h87, LEN2, CYC4, CLS_MOV_DIR_IND);
    run(8'ha6, LEN2, CYC4, CLS_MOV_IND_DIR); run(8'h90, LEN3, CYC4, CLS_MOV_DATA_POINTER);
    run(8'h93, LEN1, CYC4, CLS_CODE_READ); run(8'h83, LEN1, CYC4, CLS_CODE_READ);
    run(8'he0, LEN1, CYC4, CLS_XDATA_RD); run(8'he3, LEN1, CYC4, CLS_XDATA_RD);
    run(8'hf0, LEN1, CYC4, CLS_XDATA_WR); run(8'hf2, LEN1, CYC4, CLS_XDATA_WR);
    run(8'hc0, LEN2, CYC4, CLS_PUSH); run(8'hd0, LEN2, CYC4, CLS_POP);
    run(8'hc5, LEN2, CYC2, CLS_XCH); run(8'hc6, LEN1, CYC2, CLS_XCH);
    run(8'hd7, LEN1, CYC2, CLS_NIBBLE_XCH); run(8'h82, LEN2, CYC4, CLS_BIT_LOGIC);
    run(8'hb0, LEN2, CYC4, CLS_BIT_LOGIC); run(8'h72, LEN2, CYC4, CLS_BIT_LOGIC);
    run(8'ha0, LEN2, CYC4, CLS_BIT_LOGIC); run(8'ha2, LEN2, CYC2, CLS_MOV_C_BIT);
    run(8'h92, LEN2, CYC4, CLS_MOV_BIT_C); run(8'h80, LEN2, CYC4, CLS_SHORT_JUMP);
    run(8'h73, LEN1, CYC4, CLS_INDEXED_JUMP); run(8'hb5, LEN3, CYC4, CLS_COMPARE_JUMP);
    run(8'hb4, LEN3, CYC4, CLS_COMPARE_JUMP); run(8'hb6, LEN3, CYC4, CLS_COMPARE_JUMP);
    run(8'hd5, LEN3, CYC4, CLS_DECREMENT_JUMP); run(8'h24, LEN1, CYC2, CLS_NONE);
    run(8'he9, LEN1, CYC2, CLS_MOVE); run(8'h75, LEN3, CYC4, CLS_MOVE);
    run(8'hc2, LEN2, CYC2, CLS_BIT_SIMPLE); run(8'h02, LEN3, CYC4, CLS_BRANCH);
  endtask

  task automatic s_regblk;
    for (int i = 0; i < 8; i++) begin
      run(8'h78 | 8'(i), LEN2, CYC2, CLS_MOV_R_IMM);
      run(8'ha8 | 8'(i), LEN2, CYC4, CLS_MOV_R_DIR);
      run(8'hc8 | 8'(i), LEN1, CYC2, CLS_XCH);
      run(8'hb8 | 8'(i), LEN3, CYC4, CLS_COMPARE_JUMP);
      run(8'hd8 | 8'(i), LEN2, CYC4, CLS_DECREMENT_JUMP);
    end
  endtask

  task automatic s_abs;
    for (int i = 0; i < 8; i++) begin
      run({3'(i), 5'h11}, LEN2, CYC4, CLS_ABS_CALL);
      run({3'(i), 5'h01}, LEN2, CYC4, CLS_ABS_JUMP);
    end
  endtask

  // each bit jump with the tested bit high, then low
  task automatic s_bitjump;
    logic [7:0] ops [6];
    ops = '{8'h10, 8'h10, 8'h20, 8'h20, 8'h30, 8'h30};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      bit_value <= ~i[0];
      exp_tk = (ops[i] == 8'h30) ? i[0] : ~i[0];
      exp_cl = (ops[i] == 8'h10) && !i[0];
      run(ops[i], LEN3, CYC4, CLS_JUMP_BIT);
    end
    exp_tk = 1'b0;
    exp_cl = 1'b0;
  endtask

  // second opcode rides on the done cycle; slow memory stalls between bytes
  task automatic s_b2b;
    int w, gap;
    @(posedge clk_sys);
    slow <= 1'b1;
    @(negedge clk_sys);
    i_pm.q.push_back(8'h85);
    i_pm.q.push_back(8'h11);
    i_pm.q.push_back(8'h22);
    i_pm.q.push_back(8'h00);
    w = 0;
    while (instr_done !== 1'b1 && w < 100) begin
      @(negedge clk_sys);
      w++;
    end
    chk(long_dest, 16'h1122);
    gap = 0;
    do begin
      @(negedge clk_sys);
      gap++;
    end while (instr_done !== 1'b1 && gap < 20);
    chk(16'(gap), 16'h0003);
    chk(instr_opcode, 8'h00);
    chk(instr_len, LEN1);
    @(posedge clk_sys);
    slow <= 1'b0;
  endtask

  // clock enable gaps must not count as execution cycles
  task automatic s_stall;
    stall = 1'b1;
    run(8'h85, LEN3, CYC4, CLS_MOV_DIR_DIR);
    run(8'h12, LEN3, CYC4, CLS_LONG_CALL);
    run(8'h00, LEN1, CYC2, CLS_NOP);
    stall = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    bit_value = 1'b0;
    slow = 1'b0;
    stall = 1'b0;
    exp_tk = 1'b0;
    exp_cl = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cyc_cnt = 0;
    s_reset(1'b0);
    s_table;
    s_regblk;
    s_abs;
    s_bitjump;
    s_b2b;
    s_stall;
    s_reset(1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
